/* pin_mux.sv */
// multi-function pin multiplexer: strap-selected routing of seven pins
//
// Functional notes
// - mixed: gpio1-3, sda, scl, swap input, wake
// - swap input low normal, high swapped
// - serial pins are open drain, smbus or i2c
// - suspend wake output drives host sideband wake
// - swap mode: host classes, swap states, serial
// - host class: float none, low gen1, high usb2
// - host detected when class address nonzero
// - inverted swap state complements control
// - swap state follows control
// - speed mode: speeds, serial, port0 host class
// - speed: float none, low usb2, high gen1
// - gpio mode: seven pins gpio 1,2,3,6,8,10,11
// - charge mode: charge indicators, gpio 8,10,11
// - charge: float off, low bc1.2, high enabled
// - uart mode: rts,cts,dcd,serial,dtr,dsr
// - latch strap at reset release
// - six strap resistor codes give six configs
// - configs four and five have no serial function
`timescale 1ns/1ps
`include "pin_mux_params.svh"

module pin_mux
  import pin_mux_pkg::*;
(
  // clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  NRST,
  // straps
  input  wire logic [2:0]            CFG_STRAP_CODE,
  input  wire logic [1:0]            SERIAL_INTERFACE_STRAP,
  // hub core status
  input  wire logic [`ADDR_W-1:0]    USB2_HUB_ADDR,
  input  wire logic [`ADDR_W-1:0]    USB3_HUB_ADDR,
  input  wire logic                  HOST_ON_PORT1,
  input  wire logic [3:0]            PORT_CONNECTED,
  input  wire logic [3:0]            PORT_SUPERSPEED,
  input  wire logic [3:0]            PORT_CHARGE_EN,
  input  wire logic [3:0]            PORT_BC12_MODE,
  input  wire logic                  SUSPEND_WAKE,
  // gpio core side
  input  wire logic [6:0]            GPIO_OUT,
  input  wire logic [6:0]            GPIO_OE,
  output logic [6:0]                 GPIO_IN,
  // serial management core side (high means pull line low)
  input  wire logic                  SERIAL_MGMT_DATA_PULL,
  input  wire logic                  SERIAL_MGMT_CLOCK_PULL,
  output logic                       SERIAL_MGMT_DATA_IN,
  output logic                       SERIAL_MGMT_CLOCK_IN,
  output logic                       SMBUS_SLAVE_EN,
  output logic                       I2C_BRIDGE_EN,
  // uart core side
  input  wire logic                  UART_REQUEST_SEND_N,
  input  wire logic                  UART_TERMINAL_READY_N,
  output logic                       UART_CLEAR_SEND_N,
  output logic                       UART_CARRIER_DETECT_N,
  output logic                       UART_SET_READY_N,
  // role swap and latched pin configuration
  output logic                       ROLE_SWAP,
  output logic [5:0]                 PIN_CONFIG,
  // multi-function pins
  input  wire logic [`NUM_PINS-1:0]  MULTI_FUNCTION_PIN_IN,
  output logic [`NUM_PINS-1:0]       MULTI_FUNCTION_PIN_OUT,
  output logic [`NUM_PINS-1:0]       MULTI_FUNCTION_PIN_OE
);

  // ----------------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------------
  pin_cfg_t cfg;
  logic     cfg_valid;

  strap_latch u_strap (
    .clk        (SYS_CLK),
    .rst_n      (NRST),
    .strap_code (CFG_STRAP_CODE),
    .cfg        (cfg),
    .cfg_valid  (cfg_valid)
  );

  // ----------------------------------------------------------------------
  // indicator helpers
  // ----------------------------------------------------------------------
  function automatic ind_t host_class(input logic on_port);
    if (!on_port) host_class = IND_FLOAT;
    else if (USB3_HUB_ADDR != '0) host_class = IND_LOW;
    else if (USB2_HUB_ADDR != '0) host_class = IND_HIGH;
    else host_class = IND_FLOAT;
  endfunction

  function automatic ind_t speed_ind(input logic conn, input logic ss);
    if (!conn) speed_ind = IND_FLOAT;
    else speed_ind = ss ? IND_HIGH : IND_LOW;
  endfunction

  function automatic ind_t charge_ind(input logic en, input logic bc12);
    if (!en) charge_ind = IND_FLOAT;
    else charge_ind = bc12 ? IND_LOW : IND_HIGH;
  endfunction

  // ----------------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------------
  logic [`NUM_PINS-1:0] next_out;
  logic [`NUM_PINS-1:0] next_oe;
  logic [6:0]           next_gpio_in;
  logic                 next_swap;
  logic                 next_sda_in;
  logic                 next_scl_in;
  logic                 next_smb_en;
  logic                 next_i2c_en;
  logic                 next_cts_n;
  logic                 next_dcd_n;
  logic                 next_dsr_n;
  logic                 serial_pins;
  ind_t                 ind [`NUM_PINS];
  logic [`NUM_PINS-1:0] is_ind;
  logic [`NUM_PINS-1:0] pin;

  always_comb begin
    pin          = MULTI_FUNCTION_PIN_IN;
    next_out     = '0;
    next_oe      = '0;
    next_gpio_in = '0;
    next_swap    = ROLE_SWAP;
    next_cts_n   = 1'b1;
    next_dcd_n   = 1'b1;
    next_dsr_n   = 1'b1;
    is_ind       = '0;
    for (int i = 0; i < `NUM_PINS; i++) ind[i] = IND_FLOAT;
    serial_pins  = 1'b0;
    case (cfg)
      CFG_MIXED: begin
        for (int i = 0; i < 3; i++) begin
          next_out[i]     = GPIO_OUT[i];
          next_oe[i]      = GPIO_OE[i];
          next_gpio_in[i] = pin[i];
        end
        serial_pins = 1'b1;
        next_swap   = pin[`PIN_SWAP_CTL];
        next_out[6] = SUSPEND_WAKE;
        next_oe[6]  = 1'b1;
      end
      CFG_SWAP: begin
        serial_pins = 1'b1;
        next_swap   = pin[`PIN_SWAP_CTL];
        is_ind[1:0] = 2'h3;
        ind[0]      = host_class(!ROLE_SWAP);
        ind[1]      = host_class(ROLE_SWAP);
        next_out[2] = ~ROLE_SWAP;
        next_oe[2]  = 1'b1;
        next_out[6] = ROLE_SWAP;
        next_oe[6]  = 1'b1;
      end
      CFG_SPEED: begin
        serial_pins = 1'b1;
        is_ind      = 7'h67;
        for (int i = 0; i < 3; i++) ind[i] = speed_ind(PORT_CONNECTED[i], PORT_SUPERSPEED[i]);
        ind[5]      = speed_ind(PORT_CONNECTED[3], PORT_SUPERSPEED[3]);
        ind[6]      = host_class(!ROLE_SWAP);
      end
      CFG_GPIO: begin
        next_out     = GPIO_OUT;
        next_oe      = GPIO_OE;
        next_gpio_in = pin;
      end
      CFG_CHARGE: begin
        is_ind = 7'h0f;
        for (int i = 0; i < 4; i++) ind[i] = charge_ind(PORT_CHARGE_EN[i], PORT_BC12_MODE[i]);
        for (int i = 4; i < 7; i++) begin
          next_out[i]     = GPIO_OUT[i];
          next_oe[i]      = GPIO_OE[i];
          next_gpio_in[i] = pin[i];
        end
      end
      CFG_UART: begin
        serial_pins = 1'b1;
        next_out[0] = UART_REQUEST_SEND_N;
        next_oe[0]  = 1'b1;
        next_cts_n  = pin[1];
        next_dcd_n  = pin[2];
        next_out[5] = UART_TERMINAL_READY_N;
        next_oe[5]  = 1'b1;
        next_dsr_n  = pin[6];
      end
      default: next_out = '0;
    endcase
    for (int i = 0; i < `NUM_PINS; i++) begin
      if (is_ind[i]) begin
        next_out[i] = (ind[i] == IND_HIGH);
        next_oe[i]  = (ind[i] != IND_FLOAT);
      end
    end
    // open drain: only ever drive low; other modes keep their case values
    if (serial_pins) begin
      next_out[`PIN_SDA] = 1'b0;
      next_out[`PIN_SCL] = 1'b0;
      next_oe[`PIN_SDA]  = SERIAL_MGMT_DATA_PULL;
      next_oe[`PIN_SCL]  = SERIAL_MGMT_CLOCK_PULL;
    end
    next_sda_in = serial_pins ? pin[`PIN_SDA] : 1'b1;
    next_scl_in = serial_pins ? pin[`PIN_SCL] : 1'b1;
    next_smb_en = serial_pins && (SERIAL_INTERFACE_STRAP == `SIF_SMBUS);
    next_i2c_en = serial_pins && (SERIAL_INTERFACE_STRAP == `SIF_I2C);
    // hold everything released until the strap is in
    // capture edge runs on the reset config; keep it off the pin enables, role swap and serial enables
    if (!cfg_valid) begin
      next_oe     = '0;
      next_swap   = 1'b0;
      next_smb_en = 1'b0;
      next_i2c_en = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      MULTI_FUNCTION_PIN_OUT <= '0;
      MULTI_FUNCTION_PIN_OE  <= '0;
      GPIO_IN                <= '0;
      ROLE_SWAP              <= 1'b0;
      SERIAL_MGMT_DATA_IN    <= 1'b1;
      SERIAL_MGMT_CLOCK_IN   <= 1'b1;
      SMBUS_SLAVE_EN         <= 1'b0;
      I2C_BRIDGE_EN          <= 1'b0;
      UART_CLEAR_SEND_N      <= 1'b1;
      UART_CARRIER_DETECT_N  <= 1'b1;
      UART_SET_READY_N       <= 1'b1;
      PIN_CONFIG             <= '0;
    end else begin
      MULTI_FUNCTION_PIN_OUT <= next_out;
      MULTI_FUNCTION_PIN_OE  <= next_oe;
      GPIO_IN                <= next_gpio_in;
      ROLE_SWAP              <= next_swap;
      SERIAL_MGMT_DATA_IN    <= next_sda_in;
      SERIAL_MGMT_CLOCK_IN   <= next_scl_in;
      SMBUS_SLAVE_EN         <= next_smb_en;
      I2C_BRIDGE_EN          <= next_i2c_en;
      UART_CLEAR_SEND_N      <= next_cts_n;
      UART_CARRIER_DETECT_N  <= next_dcd_n;
      UART_SET_READY_N       <= next_dsr_n;
      PIN_CONFIG             <= cfg_valid ? 6'(cfg) : 6'h00;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_swap_cfg;
    cfg_valid && (cfg == CFG_SWAP);
  endsequence

  property p_swap_follow;
    @(posedge SYS_CLK) disable iff (!NRST)
      s_swap_cfg ##1 s_swap_cfg |-> ROLE_SWAP == $past(MULTI_FUNCTION_PIN_IN[`PIN_SWAP_CTL]);
  endproperty
  a_swap_follow: assert property (p_swap_follow)
    else $error("swap state does not follow control pin");

  property p_inv_state;
    @(posedge SYS_CLK) disable iff (!NRST)
      s_swap_cfg ##1 s_swap_cfg
        |-> MULTI_FUNCTION_PIN_OE[2] && MULTI_FUNCTION_PIN_OUT[2] == !$past(ROLE_SWAP);
  endproperty
  a_inv_state: assert property (p_inv_state)
    else $error("inverted swap state wrong");

  property p_state;
    @(posedge SYS_CLK) disable iff (!NRST)
      s_swap_cfg ##1 s_swap_cfg
        |-> MULTI_FUNCTION_PIN_OE[6] && MULTI_FUNCTION_PIN_OUT[6] == $past(ROLE_SWAP);
  endproperty
  a_state: assert property (p_state)
    else $error("swap state output wrong");

  property p_od;
    @(posedge SYS_CLK) disable iff (!NRST)
      PIN_CONFIG inside {6'h01, 6'h02, 6'h04, 6'h20}
        |-> !MULTI_FUNCTION_PIN_OUT[`PIN_SDA] && !MULTI_FUNCTION_PIN_OUT[`PIN_SCL];
  endproperty
  a_od: assert property (p_od)
    else $error("serial pin driven high");

  property p_no_serial;
    @(posedge SYS_CLK) disable iff (!NRST)
      PIN_CONFIG inside {6'h08, 6'h10} |-> !SMBUS_SLAVE_EN && !I2C_BRIDGE_EN;
  endproperty
  a_no_serial: assert property (p_no_serial)
    else $error("serial function enabled in gpio or charge config");

  property p_wake;
    @(posedge SYS_CLK) disable iff (!NRST)
      cfg_valid && cfg == CFG_MIXED ##1 cfg == CFG_MIXED
        |-> MULTI_FUNCTION_PIN_OUT[6] == $past(SUSPEND_WAKE);
  endproperty
  a_wake: assert property (p_wake)
    else $error("suspend wake output wrong");

  property p_speed_float;
    @(posedge SYS_CLK) disable iff (!NRST)
      cfg_valid && cfg == CFG_SPEED && !PORT_CONNECTED[0] |=> !MULTI_FUNCTION_PIN_OE[0];
  endproperty
  a_speed_float: assert property (p_speed_float)
    else $error("speed pin driven with nothing attached");

  property p_charge_float;
    @(posedge SYS_CLK) disable iff (!NRST)
      cfg_valid && cfg == CFG_CHARGE && !PORT_CHARGE_EN[1] |=> !MULTI_FUNCTION_PIN_OE[1];
  endproperty
  a_charge_float: assert property (p_charge_float)
    else $error("charge pin driven while charging off");

  property p_host_gen1;
    @(posedge SYS_CLK) disable iff (!NRST)
      cfg_valid && cfg == CFG_SWAP && !ROLE_SWAP && USB3_HUB_ADDR != '0
        |=> MULTI_FUNCTION_PIN_OE[0] && !MULTI_FUNCTION_PIN_OUT[0];
  endproperty
  a_host_gen1: assert property (p_host_gen1)
    else $error("host class not low for gen1 host");

endmodule // pin_mux

/* pin_mux_params.svh */
// constants for the multi-function pin multiplexer
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// ----------------------------------------------------------------------
// strap codes: resistor settings decoded by the strap sensor
// ----------------------------------------------------------------------
`define STRAP_PD_200K  3'h0
`define STRAP_PU_200K  3'h1
`define STRAP_PD_10K   3'h2
`define STRAP_PU_10K   3'h3
`define STRAP_PD_10R   3'h4
`define STRAP_PU_10R   3'h5

// ----------------------------------------------------------------------
// widths and pin positions (index 0 is pin one)
// ----------------------------------------------------------------------
`define NUM_PINS       7
`define ADDR_W         7
`define PIN_SDA        3
`define PIN_SCL        4
`define PIN_SWAP_CTL   5

// ----------------------------------------------------------------------
// serial-interface strap codes
// ----------------------------------------------------------------------
`define SIF_SMBUS      2'h1
`define SIF_I2C        2'h2

`endif

/* pin_mux_pkg.sv */
// types shared by the multi-function pin multiplexer
package pin_mux_pkg;

  // pin configuration, one-hot
  typedef enum logic [5:0] {
    CFG_MIXED  = 6'h01,
    CFG_SWAP   = 6'h02,
    CFG_SPEED  = 6'h04,
    CFG_GPIO   = 6'h08,
    CFG_CHARGE = 6'h10,
    CFG_UART   = 6'h20
  } pin_cfg_t;

  // three-state indicator level
  typedef enum logic [1:0] {
    IND_FLOAT = 2'h0,
    IND_LOW   = 2'h1,
    IND_HIGH  = 2'h2
  } ind_t;

endpackage

/* strap_latch.sv */
// strap capture: latches the function-select strap once after reset release
`timescale 1ns/1ps
`include "pin_mux_params.svh"

module strap_latch
  import pin_mux_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // strap code from the sensor
  input  wire logic [2:0] strap_code,
  // latched configuration
  output pin_cfg_t        cfg,
  output logic            cfg_valid
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic pin_cfg_t decode_strap(input logic [2:0] code);
    case (code)
      `STRAP_PD_200K: decode_strap = CFG_MIXED;
      `STRAP_PU_200K: decode_strap = CFG_SWAP;
      `STRAP_PD_10K:  decode_strap = CFG_SPEED;
      `STRAP_PU_10K:  decode_strap = CFG_GPIO;
      `STRAP_PD_10R:  decode_strap = CFG_CHARGE;
      `STRAP_PU_10R:  decode_strap = CFG_UART;
      // unsupported codes fall back to mixed
      default:        decode_strap = CFG_MIXED;
    endcase
  endfunction

  pin_cfg_t next_cfg;
  logic     next_cfg_valid;

  always_comb begin
    next_cfg       = cfg;
    next_cfg_valid = 1'b1;
    if (!cfg_valid) begin
      next_cfg = decode_strap(strap_code);
    end
  end

  // frozen after the first edge; only a reset reopens it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg       <= CFG_MIXED;
      cfg_valid <= 1'b0;
    end else begin
      cfg       <= next_cfg;
      cfg_valid <= next_cfg_valid;
    end
  end

  property p_cfg_frozen;
    @(posedge clk) disable iff (!rst_n)
      $past(cfg_valid) |-> $stable(cfg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("pin configuration changed after capture");

endmodule // strap_latch

/* board_model.sv */
// board-side model of the seven multi-function pin wires
`timescale 1ns/1ps

module board_model (
  // clock
  input  wire logic       clk,
  // device pin drivers
  input  wire logic [6:0] dut_out,
  input  wire logic [6:0] dut_oe,
  // board drivers
  input  wire logic [6:0] brd,
  input  wire logic [6:0] brd_oe,
  input  wire logic       uart_pd,
  // resolved wire levels
  output logic [6:0]      level
);
  logic [6:0] last = 7'h00;

  // undriven wires must not hold a stale value, so they flip every cycle
  always @(posedge clk) begin
    last <= level;
  end

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (i == 3 || i == 4) begin
        // serial lines are wired-and with board pull-ups
        level[i] = !((dut_oe[i] && !dut_out[i]) || (brd_oe[i] && !brd[i]));
      end else if (dut_oe[i]) begin
        level[i] = dut_out[i];
      end else if (brd_oe[i]) begin
        level[i] = brd[i];
      end else if (uart_pd && (i == 1 || i == 2 || i == 6)) begin
        level[i] = 1'b0;  // modem inputs pulled down without flow control
      end else begin
        level[i] = !last[i];
      end
    end
  end
endmodule  // board_model

/* programmable_function_pin_mux_tb_top.sv */
// self-checking bench for the multi-function pin multiplexer
`timescale 1ns/1ps
`include "pin_mux_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module programmable_function_pin_mux_tb_top import pin_mux_pkg::*;;
  logic       sys_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [1:0] sif = 2'h0;
  logic [6:0] a2 = 7'h00, a3 = 7'h00, gout = 7'h00, goe = 7'h00, brd = 7'h00;
  logic [6:0] brd_oe = 7'h20;
  logic [3:0] conn = 4'h0, ss = 4'h0, chg = 4'h0, bc = 4'h0;
  logic       hop1 = 1'b0, wake = 1'b0, dpull = 1'b0, cpull = 1'b0;
  logic       rts = 1'b1, dtr = 1'b1, upd = 1'b1;
  logic [6:0] gpio_in, pin_in, pin_out, pin_oe;
  logic       sd_in, sc_in, smb_en, i2c_en, cts, dcd, dsr, rswap;
  logic [5:0] pcfg;
  int         n_mismatch = 0, total_checks = 0, cyc = 0;
  pin_cfg_t   exp_c;

  always #5 sys_clk = ~sys_clk;

  pin_mux u_dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .CFG_STRAP_CODE(strap),
    .SERIAL_INTERFACE_STRAP(sif), .USB2_HUB_ADDR(a2), .USB3_HUB_ADDR(a3),
    .HOST_ON_PORT1(hop1), .PORT_CONNECTED(conn), .PORT_SUPERSPEED(ss),
    .PORT_CHARGE_EN(chg), .PORT_BC12_MODE(bc), .SUSPEND_WAKE(wake),
    .GPIO_OUT(gout), .GPIO_OE(goe), .GPIO_IN(gpio_in),
    .SERIAL_MGMT_DATA_PULL(dpull), .SERIAL_MGMT_CLOCK_PULL(cpull),
    .SERIAL_MGMT_DATA_IN(sd_in), .SERIAL_MGMT_CLOCK_IN(sc_in),
    .SMBUS_SLAVE_EN(smb_en), .I2C_BRIDGE_EN(i2c_en),
    .UART_REQUEST_SEND_N(rts), .UART_TERMINAL_READY_N(dtr),
    .UART_CLEAR_SEND_N(cts), .UART_CARRIER_DETECT_N(dcd), .UART_SET_READY_N(dsr),
    .ROLE_SWAP(rswap), .PIN_CONFIG(pcfg), .MULTI_FUNCTION_PIN_IN(pin_in),
    .MULTI_FUNCTION_PIN_OUT(pin_out), .MULTI_FUNCTION_PIN_OE(pin_oe));

  board_model u_board (.clk(sys_clk), .dut_out(pin_out), .dut_oe(pin_oe),
    .brd(brd), .brd_oe(brd_oe), .uart_pd(upd), .level(pin_in));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic pin_cfg_t cfg_of(input int k);
    case (k)
      1: return CFG_SWAP;
      2: return CFG_SPEED;
      3: return CFG_GPIO;
      4: return CFG_CHARGE;
      5: return CFG_UART;
      default: return CFG_MIXED;
    endcase
  endfunction

  // {drive, level}: usb3 address wins, low for gen1, high for usb2
  function automatic logic [1:0] host(input logic en);
    if (!en) return 2'h0;
    if (a3 != 7'h00) return 2'h2;
    if (a2 != 7'h00) return 2'h3;
    return 2'h0;
  endfunction

  function automatic void exp_pins(input pin_cfg_t c, input logic [6:0] w,
                                   output logic [6:0] eo, output logic [6:0] ev);
    logic [1:0] h0, h1;
    h0 = host(!w[5]);
    h1 = host(w[5]);
    eo = goe;
    ev = gout;
    case (c)
      CFG_MIXED: begin
        eo[6:3] = {1'b1, 1'b0, cpull, dpull};
        ev[6:3] = {wake, 3'h0};
      end
      CFG_SWAP: begin
        eo = {1'b1, 1'b0, cpull, dpull, 1'b1, h1[1], h0[1]};
        ev = {w[5], 3'h0, !w[5], h1[0], h0[0]};
      end
      CFG_SPEED: begin
        h0 = host(1'b1);
        eo = {h0[1], conn[3], cpull, dpull, conn[2:0]};
        ev = {h0[0], ss[3], 2'h0, ss[2:0]};
      end
      CFG_CHARGE: begin
        eo[3:0] = chg;
        ev[3:0] = ~bc;
      end
      CFG_UART: begin
        eo = {1'b0, 1'b1, cpull, dpull, 3'h1};
        ev = {1'b0, dtr, 4'h0, rts};
      end
      default: ;  // gpio mode keeps the core's drivers
    endcase
  endfunction

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check_all(input pin_cfg_t c);
    logic [6:0] eo, ev, gm;
    logic       ser;
    exp_pins(c, pin_in, eo, ev);
    ser = !(c inside {CFG_GPIO, CFG_CHARGE});
    gm = (c == CFG_MIXED) ? 7'h07 : (c == CFG_GPIO) ? 7'h7f : (c == CFG_CHARGE) ? 7'h70 : 7'h00;
    `CHK(pcfg, 6'(c))
    for (int i = 0; i < 7; i++) begin
      `CHK(pin_oe[i], eo[i])
      if (eo[i]) `CHK(pin_out[i], ev[i])
      if (!gm[i] || eo[i] || brd_oe[i] || i == 3 || i == 4)
        `CHK(gpio_in[i], gm[i] & pin_in[i])
    end
    `CHK(smb_en, ser && sif == `SIF_SMBUS)
    `CHK(i2c_en, ser && sif == `SIF_I2C)
    `CHK({sd_in, sc_in}, ser ? {pin_in[3], pin_in[4]} : 2'h3)
    `CHK(rswap, (c inside {CFG_MIXED, CFG_SWAP}) ? pin_in[5] : 1'b0)
    `CHK({cts, dcd, dsr}, c == CFG_UART ? {pin_in[1], pin_in[2], pin_in[6]} : 3'h7)
  endtask

  task automatic rand_in(input int j);
    a2 = (j == 0) ? 7'h00 : 7'($urandom);
    a3 = (j % 3 == 0) ? 7'h00 : 7'($urandom);
    {conn, ss, chg, bc} = 16'($urandom);
    {wake, dpull, cpull, rts, dtr, upd, hop1} = 7'($urandom);
    {gout, goe, brd, brd_oe} = 28'($urandom);
    sif = 2'($urandom);
    // modem inputs never float: driven or pulled down
    if (!upd) brd_oe = brd_oe | 7'h46;
    brd_oe = brd_oe | 7'h20;
  endtask

  task automatic do_reset(input logic [2:0] code);
    nrst = 1'b0;
    strap = code;
    repeat (5) @(negedge sys_clk);
    `CHK({pin_oe, pcfg}, 13'h0000)
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    strap = 3'($urandom);  // late strap change must be ignored
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // sequence and timeout
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    void'($urandom(58927));
    // codes six and seven are unused and fall back to mixed
    for (int k = 0; k < 8; k++) begin
      exp_c = cfg_of(k);
      do_reset(3'(k));
      for (int j = 0; j < 25; j++) begin
        rand_in(j);
        // swap-derived pins settle two edges after the control pin
        repeat (3) @(negedge sys_clk);
        check_all(exp_c);
      end
    end
    finish_test;
  end
endmodule  // programmable_function_pin_mux_tb_top
